/* logic/fsw_params.svh */
// fsw_params.svh: opcodes, bit positions, protect codes and timing counts
// assumes: included by the decode and top design files of the status/protect block
`ifndef FSW_PARAMS_SVH
`define FSW_PARAMS_SVH
// status bit positions
`define FSW_BIT_BUSY        0
`define FSW_BIT_LATCH       1
`define FSW_BIT_LEVEL_LO    2
`define FSW_BIT_LEVEL_HI    5
`define FSW_BIT_QUAD        6
`define FSW_BIT_LOCK        7
`define FSW_STATUS_RESET    8'h00
// opcodes
`define FSW_OP_SET_LATCH    8'h06
`define FSW_OP_CLR_LATCH    8'h04
`define FSW_OP_WR_STATUS    8'h01
`define FSW_OP_WR_FUNC      8'h42
`define FSW_OP_INFO_PROG    8'h62
`define FSW_OP_PAGE_PROG    8'h02
`define FSW_OP_QPROG_A      8'h32
`define FSW_OP_QPROG_B      8'h38
`define FSW_OP_SECT_A       8'hD7
`define FSW_OP_SECT_B       8'h20
`define FSW_OP_BLK32        8'h52
`define FSW_OP_BLK64        8'hD8
`define FSW_OP_CHIP_A       8'hC7
`define FSW_OP_CHIP_B       8'h60
// frame lengths in serial bits
`define FSW_LEN_OPCODE      6'd8
`define FSW_LEN_DATA        6'd16
`define FSW_LEN_ADDR        6'd32
`define FSW_CNT_MAX         6'd40
`define FSW_IDX_OP_LAST     6'd7
`define FSW_IDX_DATA_LAST   6'd15
`define FSW_IDX_ADDR_LAST   6'd31
// protect level codes
`define FSW_LVL_NONE        4'h0
`define FSW_LVL_TOP1        4'h1
`define FSW_LVL_TOP2        4'h2
`define FSW_LVL_TOP4        4'h3
`define FSW_LVL_ALL         4'h8
`define FSW_LVL_BOT4        4'hC
`define FSW_LVL_BOT2        4'hD
`define FSW_LVL_BOT1        4'hE
// internal operation time
`define FSW_CLK_PERIOD_NS   5
`define FSW_OP_TIME_NS      2000
`define FSW_OP_CYCLES       ((`FSW_OP_TIME_NS + `FSW_CLK_PERIOD_NS - 1) / `FSW_CLK_PERIOD_NS)
`endif

/* logic/fsw_pkg.sv */
// fsw_pkg: types shared by the status/protect block
// assumes: nothing beyond the compile order
package fsw_pkg;
    typedef enum logic [2:0] {
        FSW_DEN_4M   = 3'd0,
        FSW_DEN_2M   = 3'd1,
        FSW_DEN_1M   = 3'd2,
        FSW_DEN_512K = 3'd3,
        FSW_DEN_256K = 3'd4
    } fsw_density_t;
    typedef enum logic [3:0] {
        FSW_K_NONE  = 4'h0,
        FSW_K_PROG  = 4'h1,
        FSW_K_SECT  = 4'h2,
        FSW_K_BLK32 = 4'h3,
        FSW_K_BLK64 = 4'h4,
        FSW_K_CHIP  = 4'h5,
        FSW_K_WSTAT = 4'h6,
        FSW_K_WFUNC = 4'h7,
        FSW_K_INFO  = 4'h8
    } fsw_kind_t;
    typedef enum logic [1:0] {
        FSW_ST_IDLE = 2'b01,
        FSW_ST_BUSY = 2'b10
    } fsw_state_t;
endpackage

/* logic/fsw_protect_decode.sv */
// fsw_protect_decode: maps protect level code and target address to a hit
// assumes: address and level are stable registers; output is combinational
`timescale 1ns/1ps
`include "fsw_params.svh"
module fsw_protect_decode
    import fsw_pkg::*;
#(
    parameter fsw_density_t DENSITY = FSW_DEN_4M
) (
    input  wire logic [3:0]  level_i,
    input  wire logic [23:0] addr_i,
    output logic             hit_o
);
    logic [2:0] blk;
    always_comb begin
        blk   = addr_i[18:16];
        hit_o = 1'b0;
        unique case (DENSITY)
            FSW_DEN_4M: begin
                case (level_i)
                    `FSW_LVL_TOP1: hit_o = (blk == 3'd7);
                    `FSW_LVL_TOP2: hit_o = (blk >= 3'd6);
                    `FSW_LVL_TOP4: hit_o = (blk >= 3'd4);
                    `FSW_LVL_ALL:  hit_o = 1'b1;
                    `FSW_LVL_BOT4: hit_o = (blk <= 3'd3);
                    `FSW_LVL_BOT2: hit_o = (blk <= 3'd1);
                    `FSW_LVL_BOT1: hit_o = (blk == 3'd0);
                    default:       hit_o = 1'b0;
                endcase
            end
            FSW_DEN_2M: begin
                case (level_i)
                    `FSW_LVL_TOP1: hit_o = (blk[1:0] == 2'd3);
                    `FSW_LVL_TOP2: hit_o = (blk[1:0] >= 2'd2);
                    `FSW_LVL_ALL:  hit_o = 1'b1;
                    `FSW_LVL_BOT2: hit_o = (blk[1:0] <= 2'd1);
                    `FSW_LVL_BOT1: hit_o = (blk[1:0] == 2'd0);
                    default:       hit_o = 1'b0;
                endcase
            end
            FSW_DEN_1M: begin
                case (level_i)
                    `FSW_LVL_TOP1: hit_o = blk[0];
                    `FSW_LVL_ALL:  hit_o = 1'b1;
                    `FSW_LVL_BOT1: hit_o = ~blk[0];
                    default:       hit_o = 1'b0;
                endcase
            end
            default: begin
                hit_o = (level_i == `FSW_LVL_ALL);
            end
        endcase
    end
endmodule // fsw_protect_decode

/* logic/fsw_status_top.sv */
// fsw_status_top: serial flash status register and write protection logic
// assumes: spi mode 0/3 master on sclk/cs_n/mosi, all pins async to clock_i
`timescale 1ns/1ps
`include "fsw_params.svh"
module fsw_status_top
    import fsw_pkg::*;
#(
    parameter fsw_density_t DENSITY        = FSW_DEN_4M,
    parameter logic [7:0]   READ_STATUS_OP = 8'h05,
    parameter int unsigned  OP_CYCLES      = `FSW_OP_CYCLES
) (
    input  wire logic        clock_i,
    input  wire logic        nrst_i,
    input  wire logic        sclk_i,
    input  wire logic        cs_n_i,
    input  wire logic        mosi_i,
    output logic             miso_o,
    output logic             miso_oe_n_o,
    input  wire logic        quad_line_two_i,
    output logic             quad_line_two_o,
    output logic             quad_line_two_oe_n_o,
    input  wire logic        quad_line_three_i,
    output logic             quad_line_three_o,
    output logic             quad_line_three_oe_n_o,
    output logic [7:0]       status_o,
    output logic             quad_mode_o,
    output logic             pause_active_o,
    output logic             array_go_o,
    output logic [3:0]       array_kind_o,
    output logic [23:0]      array_addr_o
);
    // ==========================================================
    // pin synchronisers
    logic [4:0] pin_raw;
    logic [4:0] pin_meta;
    logic [4:0] pin_sync;
    assign pin_raw = {sclk_i, cs_n_i, mosi_i, quad_line_two_i, quad_line_three_i};
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_sync
            always_ff @(posedge clock_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    pin_meta[gi] <= 1'b1;
                    pin_sync[gi] <= 1'b1;
                end else begin
                    pin_meta[gi] <= pin_raw[gi];
                    pin_sync[gi] <= pin_meta[gi];
                end
            end
        end
    endgenerate

    // ==========================================================
    // status state
    fsw_state_t  state;
    logic        latch;
    logic [3:0]  level;
    logic        quad_en;
    logic        lock;
    logic        busy;
    logic [7:0]  status_now;
    assign busy = (state == FSW_ST_BUSY);
    assign status_now = {lock, quad_en, level, latch, busy};

    logic protect_n;
    logic pause_n;
    assign protect_n = quad_en ? 1'b1 : pin_sync[1];
    assign pause_n   = quad_en ? 1'b1 : pin_sync[0];

    // ==========================================================
    // serial edge detection
    logic sclk_prev;
    logic cs_prev;
    logic sclk_rise;
    logic sclk_fall;
    logic frame_end;
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sclk_prev <= 1'b0;
            cs_prev   <= 1'b1;
        end else begin
            sclk_prev <= pin_sync[4];
            cs_prev   <= pin_sync[3];
        end
    end
    assign sclk_rise = pin_sync[4] & ~sclk_prev & ~pin_sync[3] & pause_n;
    assign sclk_fall = ~pin_sync[4] & sclk_prev & ~pin_sync[3] & pause_n;
    assign frame_end = pin_sync[3] & ~cs_prev;

    // ==========================================================
    // instruction shifter
    logic [5:0]  bit_cnt;
    logic [31:0] shreg;
    logic [7:0]  opcode;
    logic [7:0]  wdata;
    logic [23:0] addr_reg;
    logic [31:0] next_shreg;
    assign next_shreg = {shreg[30:0], pin_sync[2]};
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            bit_cnt  <= 6'd0;
            shreg    <= 32'h0000_0000;
            opcode   <= 8'h00;
            wdata    <= 8'h00;
            addr_reg <= 24'h00_0000;
        end else if (pin_sync[3]) begin
            bit_cnt <= 6'd0;
        end else if (sclk_rise) begin
            shreg <= next_shreg;
            if (bit_cnt != `FSW_CNT_MAX) begin
                bit_cnt <= bit_cnt + 6'd1;
            end
            if (bit_cnt == `FSW_IDX_OP_LAST) begin
                opcode <= next_shreg[7:0];
            end
            if (bit_cnt == `FSW_IDX_DATA_LAST) begin
                wdata <= next_shreg[7:0];
            end
            if (bit_cnt == `FSW_IDX_ADDR_LAST) begin
                addr_reg <= next_shreg[23:0];
            end
        end
    end

    // ==========================================================
    // read status output
    logic       rd_active;
    logic [2:0] out_idx;
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rd_active   <= 1'b0;
            out_idx     <= 3'd0;
            miso_o      <= 1'b0;
            miso_oe_n_o <= 1'b1;
        end else if (pin_sync[3]) begin
            rd_active   <= 1'b0;
            out_idx     <= 3'd0;
            miso_oe_n_o <= 1'b1;
        end else begin
            if (sclk_rise && bit_cnt == `FSW_IDX_OP_LAST &&
                next_shreg[7:0] == READ_STATUS_OP) begin
                rd_active <= 1'b1;
            end
            if (sclk_fall && rd_active) begin
                miso_o      <= status_now[3'd7 - out_idx];
                miso_oe_n_o <= 1'b0;
                out_idx     <= out_idx + 3'd1;
            end
        end
    end

    // ==========================================================
    // instruction classification and acceptance
    function automatic fsw_kind_t classify(input logic [7:0] op);
        fsw_kind_t k;
        k = FSW_K_NONE;
        case (op)
            `FSW_OP_PAGE_PROG, `FSW_OP_QPROG_A, `FSW_OP_QPROG_B: k = FSW_K_PROG;
            `FSW_OP_SECT_A, `FSW_OP_SECT_B:                      k = FSW_K_SECT;
            `FSW_OP_BLK32:                                       k = FSW_K_BLK32;
            `FSW_OP_BLK64: begin
                k = (DENSITY == FSW_DEN_512K || DENSITY == FSW_DEN_256K) ?
                    FSW_K_BLK32 : FSW_K_BLK64;
            end
            `FSW_OP_CHIP_A, `FSW_OP_CHIP_B: begin
                k = (DENSITY == FSW_DEN_256K) ? FSW_K_NONE : FSW_K_CHIP;
            end
            `FSW_OP_WR_STATUS:                                   k = FSW_K_WSTAT;
            `FSW_OP_WR_FUNC:                                     k = FSW_K_WFUNC;
            `FSW_OP_INFO_PROG:                                   k = FSW_K_INFO;
            default:                                             k = FSW_K_NONE;
        endcase
        return k;
    endfunction

    function automatic logic [5:0] min_len(input fsw_kind_t k);
        logic [5:0] n;
        n = `FSW_LEN_ADDR;
        if (k == FSW_K_CHIP) begin
            n = `FSW_LEN_OPCODE;
        end else if (k == FSW_K_WSTAT || k == FSW_K_WFUNC) begin
            n = `FSW_LEN_DATA;
        end
        return n;
    endfunction

    function automatic logic is_array_op(input fsw_kind_t k);
        return (k == FSW_K_PROG || k == FSW_K_SECT || k == FSW_K_BLK32 ||
                k == FSW_K_BLK64 || k == FSW_K_CHIP);
    endfunction

    fsw_kind_t kind;
    logic      prot_hit;
    logic      locked;
    logic      len_ok;
    logic      accept;
    logic      set_ok;
    logic      clr_ok;
    assign kind   = classify(opcode);
    assign locked = lock & ~protect_n;
    assign len_ok = (bit_cnt >= min_len(kind)) && (bit_cnt[2:0] == 3'd0);

    fsw_protect_decode #(
        .DENSITY (DENSITY)
    ) u_decode (
        .level_i (level),
        .addr_i  (addr_reg),
        .hit_o   (prot_hit)
    );

    assign accept = frame_end && kind != FSW_K_NONE && !busy
                 && latch && len_ok
                 && !(kind == FSW_K_WSTAT && locked)
                 && !(is_array_op(kind) && kind != FSW_K_CHIP && prot_hit)
                 && !(kind == FSW_K_CHIP && level != `FSW_LVL_NONE);
    assign set_ok = frame_end && !busy && opcode == `FSW_OP_SET_LATCH &&
                    bit_cnt == `FSW_LEN_OPCODE;
    assign clr_ok = frame_end && !busy && opcode == `FSW_OP_CLR_LATCH &&
                    bit_cnt == `FSW_LEN_OPCODE;

    // ==========================================================
    // operation sequencer
    logic [15:0] timer;
    fsw_kind_t   pend_kind;
    logic [7:0]  pend_data;
    logic        op_done;
    assign op_done = busy && (timer == 16'h0000);
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state     <= FSW_ST_IDLE;
            timer     <= 16'h0000;
            pend_kind <= FSW_K_NONE;
            pend_data <= 8'h00;
        end else begin
            unique case (state)
                FSW_ST_IDLE: begin
                    if (accept) begin
                        state     <= FSW_ST_BUSY;
                        timer     <= 16'(OP_CYCLES - 1);
                        pend_kind <= kind;
                        pend_data <= wdata;
                    end
                end
                FSW_ST_BUSY: begin
                    if (op_done) begin
                        state <= FSW_ST_IDLE;
                    end else begin
                        timer <= timer - 16'h0001;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            latch <= 1'b0;
        end else if (set_ok) begin
            latch <= 1'b1;
        end else if (clr_ok || op_done) begin
            latch <= 1'b0;
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            level   <= 4'(`FSW_STATUS_RESET >> `FSW_BIT_LEVEL_LO);
            quad_en <= 1'b0;
            lock    <= 1'b0;
        end else if (op_done && pend_kind == FSW_K_WSTAT) begin
            level   <= pend_data[`FSW_BIT_LEVEL_HI:`FSW_BIT_LEVEL_LO];
            quad_en <= pend_data[`FSW_BIT_QUAD];
            lock    <= pend_data[`FSW_BIT_LOCK];
        end
    end

    // ==========================================================
    // registered outputs
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            status_o               <= `FSW_STATUS_RESET;
            quad_mode_o            <= 1'b0;
            pause_active_o         <= 1'b0;
            array_go_o             <= 1'b0;
            array_kind_o           <= 4'h0;
            array_addr_o           <= 24'h00_0000;
            quad_line_two_o        <= 1'b0;
            quad_line_two_oe_n_o   <= 1'b1;
            quad_line_three_o      <= 1'b0;
            quad_line_three_oe_n_o <= 1'b1;
        end else begin
            status_o       <= status_now;
            quad_mode_o    <= quad_en;
            pause_active_o <= ~pause_n;
            array_go_o     <= accept && is_array_op(kind);
            if (accept) begin
                array_kind_o <= kind;
                array_addr_o <= addr_reg;
            end
        end
    end

    // ==========================================================
    // assertions
    sequence s_set_cmd;
        set_ok;
    endsequence
    sequence s_start;
        accept;
    endsequence

    property p_latch_set;
        @(posedge clock_i) disable iff (!nrst_i) s_set_cmd |=> latch;
    endproperty
    a_latch_set: assert property (p_latch_set) else $error("latch not set");

    property p_latch_clr;
        @(posedge clock_i) disable iff (!nrst_i) clr_ok |=> !latch;
    endproperty
    a_latch_clr: assert property (p_latch_clr) else $error("latch not cleared");

    property p_latch_rise_cause;
        @(posedge clock_i) disable iff (!nrst_i) $rose(latch) |-> $past(set_ok);
    endproperty
    a_latch_rise_cause: assert property (p_latch_rise_cause)
        else $error("latch rose without set instruction");

    property p_busy_cause;
        @(posedge clock_i) disable iff (!nrst_i) $rose(busy) |-> $past(accept);
    endproperty
    a_busy_cause: assert property (p_busy_cause) else $error("busy without accept");

    property p_busy_hold;
        @(posedge clock_i) disable iff (!nrst_i) s_start |=> busy [*8];
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");

    property p_done_clears;
        @(posedge clock_i) disable iff (!nrst_i) $fell(busy) |-> !latch;
    endproperty
    a_done_clears: assert property (p_done_clears) else $error("latch kept after op");

    property p_reject_no_latch;
        @(posedge clock_i) disable iff (!nrst_i)
            (frame_end && !latch && !busy) |=> !busy && $stable(level) && $stable(lock);
    endproperty
    a_reject_no_latch: assert property (p_reject_no_latch)
        else $error("write ran without latch");

    property p_lock_blocks;
        @(posedge clock_i) disable iff (!nrst_i)
            (frame_end && kind == FSW_K_WSTAT && locked) |=> !busy;
    endproperty
    a_lock_blocks: assert property (p_lock_blocks) else $error("locked write accepted");

    property p_protect_blocks;
        @(posedge clock_i) disable iff (!nrst_i)
            (frame_end && is_array_op(kind) && kind != FSW_K_CHIP && prot_hit)
            |=> !array_go_o ##1 !array_go_o;
    endproperty
    a_protect_blocks: assert property (p_protect_blocks)
        else $error("protected region written");

    property p_chip_levels;
        @(posedge clock_i) disable iff (!nrst_i)
            (array_go_o && array_kind_o == FSW_K_CHIP) |-> level == `FSW_LVL_NONE;
    endproperty
    a_chip_levels: assert property (p_chip_levels)
        else $error("chip erase with protection set");

    property p_nv_stable;
        @(posedge clock_i) disable iff (!nrst_i)
            !(op_done && pend_kind == FSW_K_WSTAT) |=> $stable(quad_en) && $stable(lock);
    endproperty
    a_nv_stable: assert property (p_nv_stable) else $error("nv bits changed");
endmodule // fsw_status_top

/* test/flash_status_write_protect_test.sv */
// flash_status_write_protect_test: self-checking bench of the status/protect block
// assumes: fsw_spi_master plays the far side; OP_CYCLES shortened to 10;
// a smallest-density instance listens on the same link
`timescale 1ns/1ps
`include "fsw_params.svh"
`define CHK(nm, e, g) begin comparisons++; if ((e) !== (g)) begin mismatches++; \
    $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module flash_status_write_protect_test
    import fsw_pkg::*;
;
    logic        clock_i = 1'b0;
    logic        nrst_i = 1'b0;
    logic        wp_pin = 1'b1;
    logic        pause_pin = 1'b1;
    logic        sclk, cs_n, mosi, go, go_s, miso, miso_oe_n, quad, paused;
    logic        q2_out, q2_oe_n, q3_out, q3_oe_n;
    logic [3:0]  kind_s;
    logic [7:0]  rx;
    localparam logic [7:0] RD_OP = 8'h05;
    logic [7:0]  status;
    logic [3:0]  kind;
    logic [23:0] addr;
    logic [27:0] notes[$];
    logic [27:0] nt;
    logic [31:0] rnd = 32'd24;
    int          mismatches = 0;
    int          comparisons = 0;
    int          cycles = 0;
    logic [7:0]  ops[7] = '{8'h02, 8'h32, 8'h38, 8'hD7, 8'h20, 8'h52, 8'hD8};
    logic [3:0]  kinds[7] = '{4'h1, 4'h1, 4'h1, 4'h2, 4'h2, 4'h3, 4'h4};
    always #2.5 clock_i = ~clock_i;
    fsw_spi_master spi (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso),
        .miso_oe_n_i(miso_oe_n), .rx_byte_o(rx));
    fsw_status_top #(.OP_CYCLES(10)) dut_u (
        .clock_i(clock_i), .nrst_i(nrst_i), .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi),
        .miso_o(miso), .miso_oe_n_o(miso_oe_n), .quad_line_two_i(wp_pin),
        .quad_line_two_o(q2_out), .quad_line_two_oe_n_o(q2_oe_n),
        .quad_line_three_i(pause_pin), .quad_line_three_o(q3_out),
        .quad_line_three_oe_n_o(q3_oe_n), .status_o(status), .quad_mode_o(quad),
        .pause_active_o(paused), .array_go_o(go), .array_kind_o(kind), .array_addr_o(addr));
    fsw_status_top #(.DENSITY(FSW_DEN_256K), .OP_CYCLES(10)) dut_small_u (
        .clock_i(clock_i), .nrst_i(nrst_i), .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi),
        .miso_o(), .miso_oe_n_o(), .quad_line_two_i(wp_pin), .quad_line_two_o(),
        .quad_line_two_oe_n_o(), .quad_line_three_i(pause_pin), .quad_line_three_o(),
        .quad_line_three_oe_n_o(), .status_o(), .quad_mode_o(), .pause_active_o(),
        .array_go_o(go_s), .array_kind_o(kind_s), .array_addr_o());
    function automatic logic [31:0] xorshift(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction
    // ===========================================
    // monitor: each start pulse takes the oldest note
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 60000) begin
            mismatches++;
            close_out();
        end else begin
            if (go === 1'b1) begin
                nt = (notes.size() > 0) ? notes.pop_front() : 28'hFFF_FFFF;
                `CHK("kind", nt[27:24], kind)
                // chip erase carries no address, the port keeps a stale one
                if (nt[27:24] != FSW_K_CHIP) `CHK("addr", nt[23:0], addr)
            end
            if (go_s === 1'b1) begin
                `CHK("small kind", 1'b0, kind_s > FSW_K_BLK32)
            end
        end
    end
    task automatic close_out;
        $display("counts: %0d comparisons, %0d mismatches", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // one frame, then busy is checked high or low and the operation left to end
    task automatic op(input logic [39:0] b, input int n, input logic ok, input logic [3:0] k);
        if (ok && k != FSW_K_WSTAT) notes.push_back({k, b[23:0]});
        spi.frame(b, n);
        repeat (7) @(posedge clock_i);
        `CHK("busy", ok, status[`FSW_BIT_BUSY])
        repeat (20) @(posedge clock_i);
        `CHK("idle", 1'b0, status[`FSW_BIT_BUSY])
    endtask
    task automatic latch;
        spi.frame({32'h0, `FSW_OP_SET_LATCH}, 8);
        repeat (8) @(posedge clock_i);
    endtask
    task automatic wstat(input logic [7:0] d, input logic ok, input logic [7:0] exp);
        latch();
        op({24'h0, `FSW_OP_WR_STATUS, d}, 16, ok, FSW_K_WSTAT);
        `CHK("status", exp, status)
    endtask
    task automatic read_status_cmd(input logic [7:0] exp);
        spi.frame({24'h0, RD_OP, 8'h00}, 16);
        repeat (8) @(posedge clock_i);
        `CHK("read status", exp, rx)
        `CHK("miso released", 1'b1, miso_oe_n)
    endtask
    initial begin
        repeat (10) @(posedge clock_i);
        nrst_i <= 1'b1;
        repeat (5) @(posedge clock_i);
        `CHK("reset", 8'h00, status)
        latch();
        `CHK("set latch", 8'h02, status)
        read_status_cmd(8'h02);
        spi.frame({32'h0, `FSW_OP_CLR_LATCH}, 8);
        repeat (8) @(posedge clock_i);
        `CHK("clear latch", 8'h00, status)
        op({24'h0, `FSW_OP_WR_STATUS, 8'h0C}, 16, 1'b0, FSW_K_WSTAT);
        `CHK("no latch", 8'h00, status)
        $display("test latch done");
        // data bit1 set must not reach the latch; quad kept off
        wstat(8'h0E, 1'b1, 8'h0C);
        latch();
        op({8'h0, `FSW_OP_PAGE_PROG, 24'h07_0000}, 32, 1'b0, FSW_K_PROG);
        `CHK("refused", 8'h0E, status)
        op({32'h0, `FSW_OP_CHIP_A}, 8, 1'b0, FSW_K_CHIP);
        for (int i = 0; i < 7; i++) begin
            rnd = xorshift(rnd);
            latch();
            op({8'h0, ops[i], 6'h0, rnd[17:0]}, 32, 1'b1, kinds[i]);
            `CHK("latch cleared", 8'h0C, status)
        end
        $display("test protect done");
        wstat(8'h80, 1'b1, 8'h80);
        read_status_cmd(8'h80);
        wp_pin <= 1'b0;
        wstat(8'h0C, 1'b0, 8'h82);
        wp_pin <= 1'b1;
        wstat(8'h00, 1'b1, 8'h00);
        // protect and pause are driven here, never strapped, so quad may be set
        wstat(8'hC0, 1'b1, 8'hC0);
        `CHK("quad mode", 1'b1, quad)
        wp_pin <= 1'b0;
        wstat(8'h00, 1'b1, 8'h00);
        wp_pin <= 1'b1;
        pause_pin <= 1'b0;
        latch();
        `CHK("paused", 1'b1, paused)
        `CHK("pause holds", 8'h00, status)
        pause_pin <= 1'b1;
        latch();
        op({32'h0, `FSW_OP_CHIP_B}, 8, 1'b1, FSW_K_CHIP);
        `CHK("quad lines", 4'h5, {q2_out, q2_oe_n, q3_out, q3_oe_n})
        $display("test lock done");
        `CHK("notes left", 0, notes.size())
        close_out();
    end
endmodule // flash_status_write_protect_test

/* test/fsw_spi_master.sv */
// fsw_spi_master: behavioural spi master sending instruction frames
// assumes: mode 0, sclk stands low between frames, link period 160 ns
`timescale 1ns/1ps
module fsw_spi_master (
    output logic       sclk_o,
    output logic       cs_n_o,
    output logic       mosi_o,
    input  logic       miso_i,
    input  logic       miso_oe_n_i,
    output logic [7:0] rx_byte_o
);
    // a released data out line shows the inverse, so late drive is caught
    logic miso_seen;
    assign miso_seen = miso_oe_n_i ? ~miso_i : miso_i;
    initial begin
        sclk_o    = 1'b0;
        cs_n_o    = 1'b1;
        mosi_o    = 1'b1;
        rx_byte_o = 8'h00;
    end
    // ===========================================
    // frame: n bits msb first, cs rise commits; last 8 bits in are kept
    task automatic frame(input logic [39:0] bits, input int n);
        cs_n_o <= 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            mosi_o <= bits[i];
            #80;
            sclk_o    <= 1'b1;
            rx_byte_o <= {rx_byte_o[6:0], miso_seen};
            #80;
            sclk_o <= 1'b0;
        end
        mosi_o <= ~mosi_o;
        #80;
        cs_n_o <= 1'b1;
    endtask
endmodule // fsw_spi_master
